//--- pci_err_map.sv
/*
 * Maps a parameter store status onto the channel's error number.
 * Purely combinational; assumes the status codes of pci_pkg.
 */
`default_nettype none
module pci_err_map
    import pci_pkg::*;
(
    input wire logic [3:0] status,
    input wire logic type_mismatch,
    output logic [31:0] err_num
);
    // ==========================================================
    // Status to error number
    // Type mismatch wins: the store status is not looked at in that case
    always_comb begin
        err_num = PCI_ERR_OTHER;
        if (type_mismatch) begin
            err_num = PCI_ERR_DATA_TYPE;
        end else begin
            unique case (status)
                PCI_ST_BAD_PNUM: err_num = PCI_ERR_BAD_PNUM;
                PCI_ST_READ_ONLY: err_num = PCI_ERR_READ_ONLY;
                PCI_ST_LIMIT: err_num = PCI_ERR_LIMIT;
                PCI_ST_SUBINDEX: err_num = PCI_ERR_SUBINDEX;
                PCI_ST_NO_ARRAY: err_num = PCI_ERR_NO_ARRAY;
                PCI_ST_RESET_ONLY: err_num = PCI_ERR_RESET_ONLY;
                PCI_ST_OP_STATE: err_num = PCI_ERR_OP_STATE;
                default: err_num = PCI_ERR_OTHER;
            endcase
        end
    end
endmodule : pci_err_map
`default_nettype wire

//--- pci_interp.sv
/*
 * Parameter channel interpreter: decodes the 8-byte request slot of
 * the cyclic data, runs one access to the parameter store and holds
 * the answer in the 8-byte response slot.
 * Assumes the cyclic exchange gives a one-cycle cyc_strobe with a
 * stable request slot, and a parameter store that answers a one-cycle
 * store_req with store_done some cycles later.
 */
`default_nettype none
module pci_interp
    import pci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cyc_strobe,
    input wire logic [63:0] req_slot,
    output logic [63:0] rsp_slot,
    output logic rsp_update,
    output logic busy,
    output logic store_req,
    output logic store_write,
    output logic store_array,
    output logic store_count,
    output logic [10:0] store_pnum,
    output logic [15:0] store_sub,
    output logic [31:0] store_wdata,
    input wire logic store_done,
    input wire logic [3:0] store_status,
    input wire logic store_dword,
    input wire logic [31:0] store_rdata
);
    // ==========================================================
    // Request slot unpacking, most significant byte first
    logic [15:0] in_id;
    logic [15:0] in_sub;
    logic [31:0] in_val;
    logic [3:0] in_code;
    logic [10:0] in_pnum;
    logic [63:0] in_bytes;
    genvar gi;
    // Byte k of the slot sits at bits 63-8k downward
    for (gi = 0; gi < PCI_CHAN_BYTES; gi++) begin : g_bytes
        assign in_bytes[63 - 8 * gi -: 8] = req_slot[63 - 8 * gi -: 8];
    end
    assign in_id = {in_bytes[63 - 8 * PCI_ID_HI_BYTE -: 8],
                    in_bytes[63 - 8 * PCI_ID_LO_BYTE -: 8]};
    assign in_sub = {in_bytes[63 - 8 * PCI_SUB_HI_BYTE -: 8],
                     in_bytes[63 - 8 * PCI_SUB_LO_BYTE -: 8]};
    assign in_val = in_bytes[63 - 8 * PCI_VAL_BYTE0 -: 32];
    assign in_code = in_id[PCI_CODE_MSB:PCI_CODE_LSB];
    assign in_pnum = in_id[PCI_PNUM_MSB:PCI_PNUM_LSB];

    // ==========================================================
    // Request classification
    logic req_known;
    logic req_write;
    logic req_array;
    logic req_cnt;
    logic req_want_dw;
    always_comb begin
        req_known = 1'b1;
        req_write = 1'b0;
        req_array = 1'b0;
        req_cnt = 1'b0;
        req_want_dw = 1'b0;
        unique case (in_code)
            PCI_REQ_READ: req_write = 1'b0;
            PCI_REQ_WR_WORD: req_write = 1'b1;
            PCI_REQ_WR_DWORD: begin
                req_write = 1'b1;
                req_want_dw = 1'b1;
            end
            PCI_REQ_ARR_READ: req_array = 1'b1;
            PCI_REQ_ARR_WR_WORD: begin
                req_write = 1'b1;
                req_array = 1'b1;
            end
            PCI_REQ_ARR_WR_DWORD: begin
                req_write = 1'b1;
                req_array = 1'b1;
                req_want_dw = 1'b1;
            end
            PCI_REQ_ARR_COUNT: begin
                req_array = 1'b1;
                req_cnt = 1'b1;
            end
            default: req_known = 1'b0;
        endcase
    end

    // ==========================================================
    // Error number mapping
    logic hold_dw;
    logic type_bad;
    logic [31:0] err_num;
    // Write width must match the stored type of the parameter; uses the
    // registered access kind, as the slot may change while waiting
    assign type_bad = store_write & (store_dword != hold_dw);
    pci_err_map u_err_map (
        .status(store_status),
        .type_mismatch(type_bad),
        .err_num(err_num)
    );

    // ==========================================================
    // Sequencer state
    pci_state_t state;
    pci_state_t next_state;
    logic [15:0] held_id;
    logic [15:0] next_held_id;
    logic [15:0] held_sub;
    logic [15:0] next_held_sub;
    logic [31:0] held_val;
    logic [31:0] next_held_val;
    logic next_hold_dw;
    logic [63:0] next_rsp_slot;
    logic next_rsp_update;
    logic next_store_req;
    logic next_store_write;
    logic next_store_array;
    logic next_store_count;
    logic [3:0] ok_code;
    logic new_cmd;

    // A command is new when its words differ from the one last taken
    assign new_cmd = (in_id != held_id) || (in_sub != held_sub)
                     || (in_val != held_val);

    // Positive answer code by request kind and stored type
    always_comb begin
        ok_code = store_dword ? PCI_RSP_DWORD : PCI_RSP_WORD;
        if (store_count) begin
            ok_code = PCI_RSP_ARR_COUNT;
        end else if (store_array) begin
            ok_code = store_dword ? PCI_RSP_ARR_DWORD
                                  : PCI_RSP_ARR_WORD;
        end
    end

    // Next-state logic; the request slot is only looked at in IDLE
    // and HOLD, so a second request cannot disturb one in flight
    always_comb begin
        next_state = state;
        next_held_id = held_id;
        next_held_sub = held_sub;
        next_held_val = held_val;
        next_hold_dw = hold_dw;
        next_rsp_slot = rsp_slot;
        next_rsp_update = 1'b0;
        next_store_req = 1'b0;
        next_store_write = store_write;
        next_store_array = store_array;
        next_store_count = store_count;
        unique case (state)
            PCI_IDLE, PCI_HOLD: begin
                if (cyc_strobe && (state == PCI_IDLE || new_cmd)) begin
                    next_held_id = in_id;
                    next_held_sub = in_sub;
                    next_held_val = in_val;
                    next_hold_dw = req_want_dw;
                    if (in_code == PCI_REQ_NONE) begin
                        // Idle request clears the answer to code 0
                        next_rsp_slot = {PCI_RSP_NONE, 1'b0, in_pnum,
                                         in_sub, in_val};
                        next_rsp_update = 1'b1;
                        next_state = PCI_HOLD;
                    end else if (!req_known) begin
                        next_rsp_slot = {PCI_RSP_ERROR, 1'b0, in_pnum,
                                         in_sub, PCI_ERR_OTHER};
                        next_rsp_update = 1'b1;
                        next_state = PCI_HOLD;
                    end else begin
                        next_store_req = 1'b1;
                        next_store_write = req_write;
                        next_store_array = req_array;
                        next_store_count = req_cnt;
                        next_state = PCI_WAIT;
                    end
                end
            end
            PCI_WAIT: begin
                if (store_done) begin
                    next_rsp_update = 1'b1;
                    next_state = PCI_HOLD;
                    if (store_status != PCI_ST_OK || type_bad) begin
                        next_rsp_slot = {PCI_RSP_ERROR, 1'b0,
                                         held_id[PCI_PNUM_MSB:PCI_PNUM_LSB],
                                         held_sub, err_num};
                    end else if (store_write) begin
                        next_rsp_slot = {ok_code, 1'b0,
                                         held_id[PCI_PNUM_MSB:PCI_PNUM_LSB],
                                         held_sub, held_val};
                    end else begin
                        next_rsp_slot = {ok_code, 1'b0,
                                         held_id[PCI_PNUM_MSB:PCI_PNUM_LSB],
                                         held_sub, store_rdata};
                    end
                end
            end
            default: next_state = PCI_IDLE;
        endcase
    end

    // ==========================================================
    // State registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= PCI_IDLE;
            held_id <= PCI_RST_ID;
            held_sub <= PCI_RST_SUB;
            held_val <= PCI_RST_VAL;
            hold_dw <= 1'b0;
            rsp_slot <= {PCI_RST_ID, PCI_RST_SUB, PCI_RST_VAL};
            rsp_update <= 1'b0;
            store_req <= 1'b0;
            store_write <= 1'b0;
            store_array <= 1'b0;
            store_count <= 1'b0;
        end else begin
            state <= next_state;
            held_id <= next_held_id;
            held_sub <= next_held_sub;
            held_val <= next_held_val;
            hold_dw <= next_hold_dw;
            rsp_slot <= next_rsp_slot;
            rsp_update <= next_rsp_update;
            store_req <= next_store_req;
            store_write <= next_store_write;
            store_array <= next_store_array;
            store_count <= next_store_count;
        end
    end

    // Store address and data come from the held request, so they are
    // registered and stable for the whole access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state == PCI_WAIT);
        end
    end
    assign store_pnum = held_id[PCI_PNUM_MSB:PCI_PNUM_LSB];
    assign store_sub = held_sub;
    assign store_wdata = held_val;

    // ==========================================================
    // Checks
    a_spont_zero: assert property (@(posedge sys_clk) disable iff (rst)
        rsp_update |-> !rsp_slot[48 + PCI_SPONT_BIT])
        else $error("spontaneous bit set in answer");
    a_one_request: assert property (@(posedge sys_clk) disable iff (rst)
        store_req |-> $past(state) != PCI_WAIT)
        else $error("second store access while busy");
    a_write_echo: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_WAIT && store_done && store_write
         && store_status == PCI_ST_OK && !type_bad)
        |=> rsp_slot[31:0] == held_val
            && rsp_slot[47:32] == held_sub)
        else $error("write answer does not echo request");
    a_error_code: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_WAIT && store_done && store_status != PCI_ST_OK)
        |=> rsp_slot[63:60] == PCI_RSP_ERROR)
        else $error("failed access not answered with error code");
    a_count_code: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_WAIT && store_done && store_count
         && store_status == PCI_ST_OK)
        |=> rsp_slot[63:60] == PCI_RSP_ARR_COUNT)
        else $error("element count answered with wrong code");
    a_array_code: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_WAIT && store_done && store_array && !store_count
         && store_status == PCI_ST_OK && !type_bad)
        |=> rsp_slot[63:60] == ($past(store_dword) ? PCI_RSP_ARR_DWORD
                                                   : PCI_RSP_ARR_WORD))
        else $error("array answer code wrong");
    a_plain_code: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_WAIT && store_done && !store_array
         && store_status == PCI_ST_OK && !type_bad)
        |=> rsp_slot[63:60] == ($past(store_dword) ? PCI_RSP_DWORD
                                                   : PCI_RSP_WORD))
        else $error("plain answer code wrong");
    a_answer_held: assert property (@(posedge sys_clk) disable iff (rst)
        (state == PCI_HOLD && !(cyc_strobe && new_cmd))
        |=> $stable(rsp_slot))
        else $error("answer changed without new command");
    a_none_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (state != PCI_WAIT && cyc_strobe && in_code == PCI_REQ_NONE
         && (state == PCI_IDLE || new_cmd))
        |=> rsp_update && rsp_slot[63:60] == PCI_RSP_NONE)
        else $error("idle request not answered with code 0");
endmodule : pci_interp
`default_nettype wire

//--- pci_pkg.sv
/*
 * Constants, codes and types for the parameter channel interpreter.
 * Assumes a single 125 MHz system clock domain.
 */
`default_nettype none
package pci_pkg;
    // ==========================================================
    // Channel layout (8 bytes, most significant byte first)
    localparam int PCI_CHAN_BYTES = 8;
    localparam int PCI_ID_HI_BYTE = 0;
    localparam int PCI_ID_LO_BYTE = 1;
    localparam int PCI_SUB_HI_BYTE = 2;
    localparam int PCI_SUB_LO_BYTE = 3;
    localparam int PCI_VAL_BYTE0 = 4;
    // ==========================================================
    // Identifier word fields
    localparam int PCI_CODE_MSB = 15;
    localparam int PCI_CODE_LSB = 12;
    localparam int PCI_SPONT_BIT = 11;
    localparam int PCI_PNUM_MSB = 10;
    localparam int PCI_PNUM_LSB = 0;
    // ==========================================================
    // Request codes
    localparam logic [3:0] PCI_REQ_NONE = 4'h0;
    localparam logic [3:0] PCI_REQ_READ = 4'h1;
    localparam logic [3:0] PCI_REQ_WR_WORD = 4'h2;
    localparam logic [3:0] PCI_REQ_WR_DWORD = 4'h3;
    localparam logic [3:0] PCI_REQ_ARR_READ = 4'h6;
    localparam logic [3:0] PCI_REQ_ARR_WR_WORD = 4'h7;
    localparam logic [3:0] PCI_REQ_ARR_WR_DWORD = 4'h8;
    localparam logic [3:0] PCI_REQ_ARR_COUNT = 4'h9;
    // Response codes
    localparam logic [3:0] PCI_RSP_NONE = 4'h0;
    localparam logic [3:0] PCI_RSP_WORD = 4'h1;
    localparam logic [3:0] PCI_RSP_DWORD = 4'h2;
    localparam logic [3:0] PCI_RSP_ARR_WORD = 4'h4;
    localparam logic [3:0] PCI_RSP_ARR_DWORD = 4'h5;
    localparam logic [3:0] PCI_RSP_ARR_COUNT = 4'h6;
    localparam logic [3:0] PCI_RSP_ERROR = 4'h7;
    // ==========================================================
    // Error numbers
    localparam logic [31:0] PCI_ERR_BAD_PNUM = 32'h0000_0000;
    localparam logic [31:0] PCI_ERR_READ_ONLY = 32'h0000_0001;
    localparam logic [31:0] PCI_ERR_LIMIT = 32'h0000_0002;
    localparam logic [31:0] PCI_ERR_SUBINDEX = 32'h0000_0003;
    localparam logic [31:0] PCI_ERR_NO_ARRAY = 32'h0000_0004;
    localparam logic [31:0] PCI_ERR_DATA_TYPE = 32'h0000_0005;
    localparam logic [31:0] PCI_ERR_RESET_ONLY = 32'h0000_0006;
    localparam logic [31:0] PCI_ERR_OP_STATE = 32'h0000_0011;
    localparam logic [31:0] PCI_ERR_OTHER = 32'h0000_0012;
    // ==========================================================
    // Store access status from the parameter store
    localparam logic [3:0] PCI_ST_OK = 4'h0;
    localparam logic [3:0] PCI_ST_BAD_PNUM = 4'h1;
    localparam logic [3:0] PCI_ST_READ_ONLY = 4'h2;
    localparam logic [3:0] PCI_ST_LIMIT = 4'h3;
    localparam logic [3:0] PCI_ST_SUBINDEX = 4'h4;
    localparam logic [3:0] PCI_ST_NO_ARRAY = 4'h5;
    localparam logic [3:0] PCI_ST_RESET_ONLY = 4'h6;
    localparam logic [3:0] PCI_ST_OP_STATE = 4'h7;
    localparam logic [3:0] PCI_ST_OTHER = 4'h8;
    // ==========================================================
    // Reset values
    localparam logic [15:0] PCI_RST_ID = 16'h0000;
    localparam logic [15:0] PCI_RST_SUB = 16'h0000;
    localparam logic [31:0] PCI_RST_VAL = 32'h0000_0000;
    localparam logic [7:0] PCI_RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        PCI_IDLE = 2'b00,
        PCI_WAIT = 2'b01,
        PCI_HOLD = 2'b10
    } pci_state_t;
endpackage : pci_pkg
`default_nettype wire

//--- pci_store_model.sv
/*
 * Behavioural parameter store that answers the interpreter's accesses.
 * Assumes one sys_clk domain and a one-cycle store_req from the block.
 */
`default_nettype none
module pci_store_model
    import pci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic store_req,
    input wire logic [10:0] store_pnum,
    input wire logic [15:0] store_sub,
    input wire logic [3:0] cfg_status,
    input wire logic cfg_dword,
    input wire logic [7:0] cfg_delay,
    output logic store_done,
    output logic [3:0] store_status,
    output logic store_dword,
    output logic [31:0] store_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Access timing
    logic pend;
    logic [7:0] cnt;
    logic [31:0] val;

    // Delay set by the bench, so slow and prompt answers both occur
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            cnt <= 8'h00;
            store_done <= 1'b0;
        end else begin
            store_done <= 1'b0;
            if (store_req) begin
                pend <= 1'b1;
                cnt <= cfg_delay;
            end else if (pend) begin
                if (cnt == 8'h00) begin
                    pend <= 1'b0;
                    store_done <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end

    // Value tied to number and subindex; garbage outside done
    assign val = {5'b0_0000, store_pnum, store_sub};
    assign store_rdata = store_done ? val : ~val;
    assign store_status = store_done ? cfg_status : ~cfg_status;
    assign store_dword = store_done ? cfg_dword : ~cfg_dword;
endmodule : pci_store_model
`default_nettype wire

//--- tb_param_channel_interpreter.sv
/*
 * Self-checking bench for pci_interp; the bench plays the controller.
 * Assumes pci_pkg and pci_store_model are compiled first.
 */
`default_nettype none
module tb_param_channel_interpreter
    import pci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, cyc_strobe, rsp_update, busy, store_req;
    logic store_write, store_array, store_count;
    logic store_done, store_dword, cfg_dword;
    logic [63:0] req_slot, rsp_slot;
    logic [10:0] store_pnum;
    logic [15:0] store_sub;
    logic [31:0] store_rdata, store_wdata;
    logic [3:0] store_status, cfg_status;
    logic [7:0] cfg_delay;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    pci_interp dut (.sys_clk(sys_clk), .rst(rst), .cyc_strobe(cyc_strobe),
        .req_slot(req_slot), .rsp_slot(rsp_slot), .rsp_update(rsp_update),
        .busy(busy), .store_req(store_req), .store_write(store_write),
        .store_array(store_array), .store_count(store_count),
        .store_pnum(store_pnum), .store_sub(store_sub),
        .store_wdata(store_wdata), .store_done(store_done),
        .store_status(store_status), .store_dword(store_dword),
        .store_rdata(store_rdata));
    pci_store_model store (.sys_clk(sys_clk), .rst(rst),
        .store_req(store_req), .store_pnum(store_pnum),
        .store_sub(store_sub), .cfg_status(cfg_status),
        .cfg_dword(cfg_dword), .cfg_delay(cfg_delay),
        .store_done(store_done), .store_status(store_status),
        .store_dword(store_dword), .store_rdata(store_rdata));

    // ==========================================================
    // Helpers
    function automatic logic [63:0] slot(logic [3:0] c, logic [10:0] p,
        logic [15:0] s, logic [31:0] v);
        return {c, 1'b0, p, s, v};
    endfunction : slot
    function automatic logic [31:0] mval(logic [10:0] p, logic [15:0] s);
        return {5'b0_0000, p, s};
    endfunction : mval
    task automatic check(string name, logic [63:0] got, logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic cfg(logic [3:0] st, logic dw, logic [7:0] dly);
        @(negedge sys_clk);
        cfg_status = st;
        cfg_dword = dw;
        cfg_delay = dly;
    endtask : cfg
    // Strobe held for one exchange only; the slot keeps its value until the next call
    task automatic strobe(logic [63:0] req);
        @(negedge sys_clk);
        cyc_strobe = 1'b1;
        req_slot = req;
        @(negedge sys_clk);
        cyc_strobe = 1'b0;
    endtask : strobe
    // Pulse looked at on falling edges, the current one included, so a
    // one-cycle answer right after the taking edge is not missed
    task automatic wait_rsp();
        int n;
        n = 0;
        while (rsp_update !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_rsp
    task automatic xact(logic [63:0] req, logic [63:0] exp);
        strobe(req);
        wait_rsp();
        check("rsp_update", 64'(rsp_update), 64'h0000_0000_0000_0001);
        check("rsp_slot", rsp_slot, exp);
    endtask : xact

    // ==========================================================
    // Scenarios
    task automatic t_reads();
        cfg(PCI_ST_OK, 1'b0, 8'h02);
        xact(slot(PCI_REQ_READ, 11'h123, 16'h0000, 32'h0000_0000),
            slot(PCI_RSP_WORD, 11'h123, 16'h0000, mval(11'h123, 16'h0000)));
        cfg(PCI_ST_OK, 1'b1, 8'h00);
        xact(slot(PCI_REQ_READ, 11'h7ff, 16'h0000, 32'h0000_0000),
            slot(PCI_RSP_DWORD, 11'h7ff, 16'h0000, mval(11'h7ff, 16'h0000)));
        xact(slot(PCI_REQ_ARR_READ, 11'h031, 16'hfffe, 32'h0000_0000),
            slot(PCI_RSP_ARR_DWORD, 11'h031, 16'hfffe, mval(11'h031, 16'hfffe)));
        cfg(PCI_ST_OK, 1'b0, 8'h05);
        xact(slot(PCI_REQ_ARR_READ, 11'h031, 16'h0003, 32'h0000_0000),
            slot(PCI_RSP_ARR_WORD, 11'h031, 16'h0003, mval(11'h031, 16'h0003)));
        xact(slot(PCI_REQ_ARR_COUNT, 11'h032, 16'h0000, 32'h0000_0000),
            slot(PCI_RSP_ARR_COUNT, 11'h032, 16'h0000, mval(11'h032, 16'h0000)));
        check("store_count", 64'(store_count), 64'h0000_0000_0000_0001);
    endtask : t_reads

    // All four write codes echo number, subindex and value
    task automatic t_writes();
        logic [3:0] rq [4] = '{PCI_REQ_WR_WORD, PCI_REQ_WR_DWORD,
            PCI_REQ_ARR_WR_WORD, PCI_REQ_ARR_WR_DWORD};
        logic [3:0] rs [4] = '{PCI_RSP_WORD, PCI_RSP_DWORD,
            PCI_RSP_ARR_WORD, PCI_RSP_ARR_DWORD};
        for (int i = 0; i < 4; i++) begin
            cfg(PCI_ST_OK, i[0], 8'h01);
            xact(slot(rq[i], 11'h040 + 11'(i), 16'h8000 + 16'(i),
                32'hcafe_0000 + 32'(i)), slot(rs[i], 11'h040 + 11'(i),
                16'h8000 + 16'(i), 32'hcafe_0000 + 32'(i)));
            check("store_wdata", 64'(store_wdata),
                64'(32'hcafe_0000 + 32'(i)));
            check("store_kind", {62'h0, store_write, store_array},
                {62'h0, 1'b1, i[1]});
        end
    endtask : t_writes

    // Every store failure maps to its error number
    task automatic t_errors();
        logic [31:0] ev [9] = '{32'h0000_0000, PCI_ERR_BAD_PNUM,
            PCI_ERR_READ_ONLY, PCI_ERR_LIMIT, PCI_ERR_SUBINDEX,
            PCI_ERR_NO_ARRAY, PCI_ERR_RESET_ONLY, PCI_ERR_OP_STATE,
            PCI_ERR_OTHER};
        for (int s = 1; s < 9; s++) begin
            cfg(4'(s), 1'b0, 8'h00);
            xact(slot(PCI_REQ_WR_WORD, 11'h200, 16'(s), 32'h0000_1111),
                slot(PCI_RSP_ERROR, 11'h200, 16'(s), ev[s]));
        end
        cfg(PCI_ST_OK, 1'b1, 8'h00);
        xact(slot(PCI_REQ_WR_WORD, 11'h201, 16'h0000, 32'h0000_0022),
            slot(PCI_RSP_ERROR, 11'h201, 16'h0000, PCI_ERR_DATA_TYPE));
        xact(slot(4'h4, 11'h202, 16'h0000, 32'h0000_0000),
            slot(PCI_RSP_ERROR, 11'h202, 16'h0000, PCI_ERR_OTHER));
    endtask : t_errors

    // Repeated slot keeps the answer; code 0 clears the way for a repeat
    task automatic t_hold();
        logic [63:0] rq, ex;
        int ups;
        rq = slot(PCI_REQ_READ, 11'h300, 16'h0000, 32'h0000_0000);
        ex = slot(PCI_RSP_WORD, 11'h300, 16'h0000, mval(11'h300, 16'h0000));
        cfg(PCI_ST_OK, 1'b0, 8'h01);
        xact(rq, ex);
        ups = 0;
        strobe(rq);
        // Falling edges from the one after the taking edge onward
        repeat (8) begin
            ups += int'(rsp_update === 1'b1);
            @(negedge sys_clk);
        end
        check("repeat_updates", 64'(ups), 64'h0000_0000_0000_0000);
        check("held_slot", rsp_slot, ex);
        xact(slot(PCI_REQ_NONE, 11'h300, 16'h0000, 32'h0000_0000),
            slot(PCI_RSP_NONE, 11'h300, 16'h0000, 32'h0000_0000));
        xact(rq, ex);
    endtask : t_hold

    // Second request while the first waits on the store is dropped
    task automatic t_busy();
        cfg(PCI_ST_OK, 1'b0, 8'h0c);
        strobe(slot(PCI_REQ_READ, 11'h005, 16'h0000, 32'h0000_0000));
        strobe(slot(PCI_REQ_READ, 11'h006, 16'h0000, 32'h0000_0000));
        check("busy", 64'(busy), 64'h0000_0000_0000_0001);
        wait_rsp();
        check("first_answer", rsp_slot, slot(PCI_RSP_WORD, 11'h005,
            16'h0000, mval(11'h005, 16'h0000)));
        check("busy_end", 64'(busy), 64'h0000_0000_0000_0000);
    endtask : t_busy

    // ==========================================================
    // Closing, clock, watchdog and main sequence
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Whole run needs well under 2000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        cyc_strobe = 1'b0;
        req_slot = 64'h0000_0000_0000_0000;
        cfg_status = PCI_ST_OK;
        cfg_dword = 1'b0;
        cfg_delay = 8'h00;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        check("reset_slot", rsp_slot, 64'h0000_0000_0000_0000);
        t_reads();
        t_writes();
        t_errors();
        t_hold();
        t_busy();
        print_verdict();
    end
endmodule : tb_param_channel_interpreter
`default_nettype wire
